// >>> rtl/aisf_top.v
// How it works
// - disabled channel reports zero data and status, no channel fault reaches LED
// - defaults enable every channel; each enable is written on its own
// - field power faults still flash the fault LED with all channels off
// - eight words: data then status, channel one through four
// - data word is full signed 16-bit count, -32768 to +32767
// - unipolar ranges never report a negative data word
// - one-to-five range limits: 32001, -1, 32767, -767
// - zero-to-five and zero-to-ten limits: 32001, 767, 32767, 0
// - bipolar limits: 32001, -32001, 32767, -32767
// - limits are checked on corrected counts, not input volts
// - summary bit 0 is the OR of qualifying fault bits
// - bit 1 shows field power fault and sets the summary
// - bit 2 shows high warning, no summary effect
// - bit 3 shows high error and sets the summary
// - bit 4 shows low warning, no summary effect
// - bit 5 shows low error; sets summary only in bipolar ranges
// - bit 6 always reads zero
// - bit 7 shows internal link fault and sets the summary
// - distributed field power faults may lag up to 15 ms; local ones do not
// - status byte sits in the low eight bits of its word
// - range per channel from five choices, bipolar ten volts by default
// - maximum count calibration is held as signed 16 bits
// - each channel averages 1 to 80 samples, default one
`timescale 1ns/1ps
`default_nettype none
`include "aisf_map.vh"
module aisf_top #(
  parameter FP_CONFIRM_CYC = `AISF_FP_DELAY_MS * `AISF_CLK_KHZ,
  parameter LED_HALF_CYC = `AISF_LED_HALF_MS * `AISF_CLK_KHZ
) (
  input wire clk_i, // 25 MHz clock
  input wire rst_i, // sync reset, active high
  input wire [63:0] sample_i, // raw counts, channel n at [16n+15:16n]
  input wire [3:0] sample_valid_i, // per-channel sample strobes
  output wire [3:0] sample_ready_o, // per-channel sample accept
  input wire cfg_defaults_i, // apply configuration defaults
  input wire cfg_wr_i, // configuration write strobe
  input wire [1:0] cfg_chan_i, // channel addressed by write
  input wire [2:0] cfg_sel_i, // parameter selector
  input wire [15:0] cfg_data_i, // parameter value
  input wire field_power_dist_fault_i, // field_power_module distribution fault
  input wire field_power_local_fault_i, // field power fault local to module
  input wire [3:0] internal_link_fault_i, // internal_link_fault per channel
  input wire image_rd_i, // island_network_adapter read strobe
  input wire [2:0] image_addr_i, // process image word index 0..7
  output wire [15:0] image_data_o, // read data word
  output wire image_ack_o, // read data valid pulse
  output wire [3:0] chan_summary_o, // channel_summary_flag per channel
  output wire fault_led_o // fault indicator, flashing
);
  wire [63:0] data_flat;
  wire [31:0] stat_flat;
  wire [3:0] fault_flat;
  // field power distribution qualifier
  reg [23:0] fp_cnt_reg;
  reg [23:0] fp_cnt_next;
  reg fp_dist_reg;
  reg fp_dist_next;
  wire fp_fault;
  always @* begin
    fp_cnt_next = fp_cnt_reg;
    fp_dist_next = fp_dist_reg;
    if (field_power_dist_fault_i == fp_dist_reg) begin
      fp_cnt_next = 24'h000000;
    end else if (fp_cnt_reg >= FP_CONFIRM_CYC[23:0] - 24'h000001) begin
      fp_cnt_next = 24'h000000;
      fp_dist_next = field_power_dist_fault_i;
    end else begin
      fp_cnt_next = fp_cnt_reg + 24'h000001;
    end
  end
  always @(posedge clk_i) begin
    if (rst_i) begin
      fp_cnt_reg <= 24'h000000;
      fp_dist_reg <= 1'b0;
    end else begin
      fp_cnt_reg <= fp_cnt_next;
      fp_dist_reg <= fp_dist_next;
    end
  end
  // distribution fault glitches are filtered; a local fault bypasses the filter
  assign fp_fault = fp_dist_reg | field_power_local_fault_i;
  genvar g;
  generate
    for (g = 0; g < `AISF_CHANNELS; g = g + 1) begin : gen_ch
      localparam [31:0] CH = g;
      reg en_reg;
      reg [2:0] range_reg;
      reg [6:0] avg_reg;
      reg [15:0] off_reg;
      reg [15:0] max_reg;
      reg [15:0] count_reg;
      reg hi_warn_reg;
      reg hi_err_reg;
      reg lo_warn_reg;
      reg lo_err_reg;
      reg bip_reg;
      reg [15:0] data_reg;
      reg [15:0] data_next;
      reg [7:0] stat_reg;
      reg [7:0] stat_next;
      reg summary;
      wire wr_here;
      wire [15:0] result;
      wire result_valid;
      wire hi_warn;
      wire hi_err;
      wire lo_warn;
      wire lo_err;
      wire bipolar;
      assign wr_here = cfg_wr_i && ({30'h00000000, cfg_chan_i} == CH);
      always @(posedge clk_i) begin
        if (rst_i || cfg_defaults_i) begin
          en_reg <= 1'b1;
          range_reg <= `AISF_RNG_DEFAULT;
          avg_reg <= `AISF_AVG_DEFAULT;
          off_reg <= `AISF_OFFSET_DEFAULT;
          max_reg <= `AISF_MAXCNT_DEFAULT;
        end else if (wr_here) begin
          case (cfg_sel_i)
            `AISF_CFG_ENABLE: begin
              en_reg <= cfg_data_i[0];
            end
            `AISF_CFG_RANGE: begin
              // undefined range codes are ignored
              if (cfg_data_i[2:0] <= `AISF_RNG_BI10 && cfg_data_i[15:3] == 13'h0000) begin
                range_reg <= cfg_data_i[2:0];
              end
            end
            `AISF_CFG_AVG: begin
              if (cfg_data_i[15:7] == 9'h000 && cfg_data_i[6:0] != 7'h00
                  && cfg_data_i[6:0] <= `AISF_AVG_MAX) begin
                avg_reg <= cfg_data_i[6:0];
              end
            end
            `AISF_CFG_OFFSET: begin
              off_reg <= cfg_data_i;
            end
            `AISF_CFG_MAXCNT: begin
              max_reg <= cfg_data_i;
            end
            default: begin
              en_reg <= en_reg;
            end
          endcase
        end
      end
      aisf_chan_proc u_proc (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sample_i(sample_i[16*g+15:16*g]),
        .sample_valid_i(sample_valid_i[g]),
        .sample_ready_o(sample_ready_o[g]),
        .avg_len_i(avg_reg),
        .offset_i(off_reg),
        .max_count_i(max_reg),
        .result_o(result),
        .result_valid_o(result_valid)
      );
      aisf_limit_eval u_limit (
        .count_i(result),
        .range_i(range_reg),
        .hi_warn_o(hi_warn),
        .hi_err_o(hi_err),
        .lo_warn_o(lo_warn),
        .lo_err_o(lo_err),
        .bipolar_o(bipolar)
      );
      // flags are replaced on each result, never sticky
      always @(posedge clk_i) begin
        if (rst_i) begin
          count_reg <= 16'h0000;
          hi_warn_reg <= 1'b0;
          hi_err_reg <= 1'b0;
          lo_warn_reg <= 1'b0;
          lo_err_reg <= 1'b0;
          bip_reg <= 1'b1;
        end else if (result_valid) begin
          count_reg <= result;
          hi_warn_reg <= hi_warn;
          hi_err_reg <= hi_err;
          lo_warn_reg <= lo_warn;
          lo_err_reg <= lo_err;
          bip_reg <= bipolar;
        end
      end
      always @* begin
        // low error only counts toward the summary in bipolar ranges
        summary = fp_fault | hi_err_reg | (lo_err_reg & bip_reg)
          | internal_link_fault_i[g];
        data_next = 16'h0000;
        stat_next = 8'h00;
        if (en_reg) begin
          // unipolar: negative counts are shown as zero
          if (!bip_reg && count_reg[15]) begin
            data_next = 16'h0000;
          end else begin
            data_next = count_reg;
          end
          stat_next[`AISF_ST_SUMMARY] = summary;
          stat_next[`AISF_ST_FIELD_PWR] = fp_fault;
          stat_next[`AISF_ST_HI_WARN] = hi_warn_reg;
          stat_next[`AISF_ST_HI_ERR] = hi_err_reg;
          stat_next[`AISF_ST_LO_WARN] = lo_warn_reg;
          stat_next[`AISF_ST_LO_ERR] = lo_err_reg;
          stat_next[`AISF_ST_SPARE] = 1'b0;
          stat_next[`AISF_ST_LINK_FLT] = internal_link_fault_i[g];
        end
      end
      always @(posedge clk_i) begin
        if (rst_i) begin
          data_reg <= 16'h0000;
          stat_reg <= 8'h00;
        end else begin
          data_reg <= data_next;
          stat_reg <= stat_next;
        end
      end
      assign data_flat[16*g+15:16*g] = data_reg;
      assign stat_flat[8*g+7:8*g] = stat_reg;
      assign fault_flat[g] = stat_reg[`AISF_ST_SUMMARY];
    end
  endgenerate
  // process image read port
  reg [15:0] rd_data_reg;
  reg [15:0] rd_data_next;
  reg rd_ack_reg;
  wire [1:0] rd_chan = image_addr_i[2:1];
  always @* begin
    rd_data_next = rd_data_reg;
    if (image_rd_i) begin
      if (image_addr_i[0]) begin
        rd_data_next = {8'h00, stat_flat[{rd_chan, 3'h0} +: 8]};
      end else begin
        rd_data_next = data_flat[{rd_chan, 4'h0} +: 16];
      end
    end
  end
  always @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_reg <= 16'h0000;
      rd_ack_reg <= 1'b0;
    end else begin
      rd_data_reg <= rd_data_next;
      rd_ack_reg <= image_rd_i;
    end
  end
  assign image_data_o = rd_data_reg;
  assign image_ack_o = rd_ack_reg;
  assign chan_summary_o = fault_flat;
  // fault indicator flasher
  reg [23:0] led_cnt_reg;
  reg [23:0] led_cnt_next;
  reg led_reg;
  reg led_next;
  // power fault flashes even with every channel disabled
  wire led_cause = fp_fault | (|fault_flat);
  always @* begin
    led_cnt_next = led_cnt_reg;
    led_next = led_reg;
    if (!led_cause) begin
      led_cnt_next = 24'h000000;
      led_next = 1'b0;
    end else if (led_cnt_reg >= LED_HALF_CYC[23:0] - 24'h000001) begin
      led_cnt_next = 24'h000000;
      led_next = ~led_reg;
    end else begin
      led_cnt_next = led_cnt_reg + 24'h000001;
    end
  end
  always @(posedge clk_i) begin
    if (rst_i) begin
      led_cnt_reg <= 24'h000000;
      led_reg <= 1'b0;
    end else begin
      led_cnt_reg <= led_cnt_next;
      led_reg <= led_next;
    end
  end
  assign fault_led_o = led_reg;
endmodule // aisf_top
`default_nettype wire

// >>> rtl/aisf_map.vh
`ifndef AISF_MAP_VH
`define AISF_MAP_VH
// process image: even word = channel count, odd word = channel status
`define AISF_IMG_WORDS 8
`define AISF_CHANNELS 4
// status byte bit positions
`define AISF_ST_SUMMARY 0
`define AISF_ST_FIELD_PWR 1
`define AISF_ST_HI_WARN 2
`define AISF_ST_HI_ERR 3
`define AISF_ST_LO_WARN 4
`define AISF_ST_LO_ERR 5
`define AISF_ST_SPARE 6
`define AISF_ST_LINK_FLT 7
// operating range codes
`define AISF_RNG_U1_5 3'h0
`define AISF_RNG_U0_5 3'h1
`define AISF_RNG_U0_10 3'h2
`define AISF_RNG_BI5 3'h3
`define AISF_RNG_BI10 3'h4
`define AISF_RNG_DEFAULT 3'h4
// limits as signed 16-bit counts
`define AISF_HI_WARN_LIM 16'h7d01
`define AISF_HI_ERR_LIM 16'h7fff
`define AISF_U15_LO_WARN 16'hffff
`define AISF_U15_LO_ERR 16'hfd01
`define AISF_U0_LO_WARN 16'h02ff
`define AISF_U0_LO_ERR 16'h0000
`define AISF_BI_LO_WARN 16'h82ff
`define AISF_BI_LO_ERR 16'h8001
// configuration write selectors
`define AISF_CFG_ENABLE 3'h0
`define AISF_CFG_RANGE 3'h1
`define AISF_CFG_AVG 3'h2
`define AISF_CFG_OFFSET 3'h3
`define AISF_CFG_MAXCNT 3'h4
// configuration defaults and bounds
`define AISF_AVG_DEFAULT 7'h01
`define AISF_AVG_MAX 7'h50
`define AISF_OFFSET_DEFAULT 16'h0000
`define AISF_MAXCNT_DEFAULT 16'h7d00
`define AISF_FULL_SCALE 16'h7d00
// timing
`define AISF_CLK_KHZ 25000
`define AISF_FP_DELAY_MS 15
`define AISF_LED_HALF_MS 250
`endif

// >>> rtl/aisf_limit_eval.v
`timescale 1ns/1ps
`default_nettype none
`include "aisf_map.vh"
module aisf_limit_eval (
  input wire [15:0] count_i, // corrected signed count
  input wire [2:0] range_i, // operating range code
  output wire hi_warn_o, // high_limit_warning
  output wire hi_err_o, // high_limit_error
  output wire lo_warn_o, // low_limit_warning
  output wire lo_err_o, // low_limit_error
  output wire bipolar_o // range is bipolar
);
  reg [15:0] lo_warn_lim;
  reg [15:0] lo_err_lim;
  always @* begin
    case (range_i)
      `AISF_RNG_U1_5: begin
        lo_warn_lim = `AISF_U15_LO_WARN;
        lo_err_lim = `AISF_U15_LO_ERR;
      end
      `AISF_RNG_U0_5, `AISF_RNG_U0_10: begin
        lo_warn_lim = `AISF_U0_LO_WARN;
        lo_err_lim = `AISF_U0_LO_ERR;
      end
      default: begin
        lo_warn_lim = `AISF_BI_LO_WARN;
        lo_err_lim = `AISF_BI_LO_ERR;
      end
    endcase
  end
  // limits are compared on counts, never on volts
  assign hi_warn_o = $signed(count_i) >= $signed(`AISF_HI_WARN_LIM);
  assign hi_err_o = $signed(count_i) >= $signed(`AISF_HI_ERR_LIM);
  assign lo_warn_o = $signed(count_i) <= $signed(lo_warn_lim);
  assign lo_err_o = $signed(count_i) <= $signed(lo_err_lim);
  assign bipolar_o = (range_i == `AISF_RNG_BI5) || (range_i == `AISF_RNG_BI10);
endmodule // aisf_limit_eval
`default_nettype wire

// >>> rtl/aisf_chan_proc.v
`timescale 1ns/1ps
`default_nettype none
`include "aisf_map.vh"
module aisf_chan_proc (
  input wire clk_i, // clock
  input wire rst_i, // sync reset
  input wire [15:0] sample_i, // raw signed converter count
  input wire sample_valid_i, // sample strobe
  output wire sample_ready_o, // able to take a sample
  input wire [6:0] avg_len_i, // samples per result, 1..80
  input wire [15:0] offset_i, // signed offset count
  input wire [15:0] max_count_i, // signed maximum count
  output reg [15:0] result_o, // corrected signed count
  output reg result_valid_o // one-cycle result strobe
);
  localparam S_ACC = 2'h0;
  localparam S_PREP = 2'h1;
  localparam S_DIV = 2'h2;
  localparam S_OUT = 2'h3;
  reg [1:0] state_reg;
  reg [23:0] sum_reg;
  reg [6:0] cnt_reg;
  reg [40:0] quo_reg;
  reg [24:0] rem_reg;
  reg [23:0] den_reg;
  reg neg_reg;
  reg [5:0] bit_reg;
  // numerator (sum - N*offset)*32000, denominator N*(max - offset)
  wire [23:0] off_x = {{8{offset_i[15]}}, offset_i};
  wire [23:0] n_off = {17'h00000, avg_len_i} * off_x;
  wire [24:0] diff = {sum_reg[23], sum_reg} - {n_off[23], n_off};
  wire [24:0] diff_mag = diff[24] ? (25'h0000000 - diff) : diff;
  wire [40:0] num_mag = {16'h0000, diff_mag} * {25'h0000000, `AISF_FULL_SCALE};
  wire [16:0] span = {max_count_i[15], max_count_i} - {offset_i[15], offset_i};
  // a degenerate calibration span must not divide by zero
  wire [16:0] span_pos = (span[16] || span == 17'h00000) ? 17'h00001 : span;
  wire [23:0] den = {17'h00000, avg_len_i} * {7'h00, span_pos};
  wire [24:0] rem_sh = {rem_reg[23:0], quo_reg[40]};
  wire rem_ge = rem_sh >= {1'b0, den_reg};
  assign sample_ready_o = (state_reg == S_ACC);
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= S_ACC;
      sum_reg <= 24'h000000;
      cnt_reg <= 7'h00;
      quo_reg <= 41'h00000000000;
      rem_reg <= 25'h0000000;
      den_reg <= 24'h000001;
      neg_reg <= 1'b0;
      bit_reg <= 6'h00;
      result_o <= 16'h0000;
      result_valid_o <= 1'b0;
    end else begin
      result_valid_o <= 1'b0;
      case (state_reg)
        S_ACC: begin
          if (sample_valid_i) begin
            sum_reg <= sum_reg + {{8{sample_i[15]}}, sample_i};
            cnt_reg <= cnt_reg + 7'h01;
            if (cnt_reg + 7'h01 >= avg_len_i) begin
              state_reg <= S_PREP;
            end
          end
        end
        S_PREP: begin
          quo_reg <= num_mag;
          rem_reg <= 25'h0000000;
          den_reg <= den;
          neg_reg <= diff[24];
          bit_reg <= 6'h29;
          state_reg <= S_DIV;
        end
        S_DIV: begin
          quo_reg <= {quo_reg[39:0], rem_ge};
          rem_reg <= rem_ge ? (rem_sh - {1'b0, den_reg}) : rem_sh;
          bit_reg <= bit_reg - 6'h01;
          if (bit_reg == 6'h01) begin
            state_reg <= S_OUT;
          end
        end
        default: begin
          // saturate to the full 16-bit two's-complement span
          if (neg_reg) begin
            result_o <= (quo_reg > 41'h00000008000) ? 16'h8000 :
              (16'h0000 - quo_reg[15:0]);
          end else begin
            result_o <= (quo_reg > 41'h00000007fff) ? 16'h7fff : quo_reg[15:0];
          end
          result_valid_o <= 1'b1;
          sum_reg <= 24'h000000;
          cnt_reg <= 7'h00;
          state_reg <= S_ACC;
        end
      endcase
    end
  end
endmodule // aisf_chan_proc
`default_nettype wire

// >>> tb/aisf_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module aisf_top_chk (
  input wire logic clk_i, // clock
  input wire logic rst_i, // sync reset
  input wire logic image_rd_i, // read strobe
  input wire logic [2:0] image_addr_i, // word index
  input wire logic [15:0] image_data_o, // read data
  input wire logic image_ack_o, // read answer
  input wire logic [3:0] chan_summary_o, // summary flags
  input wire logic fault_led_o, // fault indicator
  input wire logic [3:0] sample_ready_o // sample accept
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic st_reg;
  logic [1:0] ch_reg;
  wire st_seen = image_ack_o & st_reg;
  always @(posedge clk_i) begin
    st_reg <= image_rd_i & image_addr_i[0];
    ch_reg <= image_addr_i[2:1];
  end
  property p_ack; image_rd_i |=> image_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("read not answered");
  property p_noack; !image_rd_i |=> !image_ack_o; endproperty
  a_noack: assert property (p_noack) else $error("answer without read");
  property p_hold; !image_rd_i |=> $stable(image_data_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_upper; st_seen |-> image_data_o[15:8] == 8'h00; endproperty
  a_upper: assert property (p_upper) else $error("status upper byte set");
  property p_spare; st_seen |-> !image_data_o[6]; endproperty
  a_spare: assert property (p_spare) else $error("status bit 6 set");
  // status byte read back may lag the summary port by an edge, so only stable spans count
  property p_sum;
    image_rd_i && image_addr_i[0] && $stable(chan_summary_o) ##1 $stable(chan_summary_o)
      |-> image_data_o[0] == chan_summary_o[ch_reg];
  endproperty
  a_sum: assert property (p_sum) else $error("summary port disagrees");
  property p_fp; st_seen && image_data_o[1] |-> image_data_o[0]; endproperty
  a_fp: assert property (p_fp) else $error("power fault without summary");
  property p_err; st_seen && image_data_o[3] |-> image_data_o[0]; endproperty
  a_err: assert property (p_err) else $error("high error without summary");
  property p_link; st_seen && image_data_o[7] |-> image_data_o[0]; endproperty
  a_link: assert property (p_link) else $error("link fault without summary");
  property p_warn;
    st_seen && !image_data_o[1] && !image_data_o[3] && !image_data_o[5] && !image_data_o[7]
      |-> !image_data_o[0];
  endproperty
  a_warn: assert property (p_warn) else $error("summary without cause");
  c_sum: cover property (st_seen && image_data_o[0]);
  c_led: cover property ($rose(fault_led_o));
  c_busy: cover property ($fell(sample_ready_o[0]));
endmodule // aisf_top_chk
bind aisf_top aisf_top_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .image_rd_i(image_rd_i),
  .image_addr_i(image_addr_i), .image_data_o(image_data_o), .image_ack_o(image_ack_o),
  .chan_summary_o(chan_summary_o), .fault_led_o(fault_led_o), .sample_ready_o(sample_ready_o));
`default_nettype wire

// >>> tb/aisf_nia_model.sv
`timescale 1ns/1ps
`default_nettype none
module aisf_nia_model (
  input wire logic clk_i, // clock
  input wire logic rst_i, // sync reset
  input wire logic scan_i, // start reading all words
  input wire logic [15:0] image_data_i, // read data
  input wire logic image_ack_i, // read answer
  output logic image_rd_o, // read strobe
  output logic [2:0] image_addr_o, // word index
  output logic [127:0] words_o, // captured image
  output logic [3:0] doubt_o, // data word of channel not trusted
  output logic busy_o // scan running
);
  // adapter configuration keeps the analog global interrupt object enabled
  logic irq_en_reg;
  // one idle cycle per word swallows the answer to the repeated read
  always @(posedge clk_i) begin
    if (rst_i) begin
      image_rd_o <= 1'b0;
      image_addr_o <= 3'h0;
      irq_en_reg <= 1'b1;
      busy_o <= 1'b0;
      doubt_o <= 4'h0;
    end else if (scan_i && !busy_o && irq_en_reg) begin
      busy_o <= 1'b1;
      image_rd_o <= 1'b1;
      image_addr_o <= 3'h0;
    end else if (image_rd_o && image_ack_i) begin
      words_o[{image_addr_o, 4'h0} +: 16] <= image_data_i;
      if (image_addr_o[0])
        doubt_o[image_addr_o[2:1]] <= image_data_i[0];
      image_rd_o <= 1'b0;
      if (image_addr_o == 3'h7)
        busy_o <= 1'b0;
      else
        image_addr_o <= image_addr_o + 3'h1;
    end else if (busy_o && !image_rd_o) begin
      image_rd_o <= 1'b1;
    end
  end
endmodule // aisf_nia_model
`default_nettype wire

// >>> tb/aisf_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "aisf_map.vh"
module aisf_top_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [63:0] sample_i = 64'h0;
  logic [3:0] sample_valid_i = 4'h0;
  logic cfg_defaults_i = 1'b0;
  logic cfg_wr_i = 1'b0;
  logic [1:0] cfg_chan_i = 2'h0;
  logic [2:0] cfg_sel_i = 3'h0;
  logic [15:0] cfg_data_i = 16'h0;
  logic fp_dist = 1'b0;
  logic fp_local = 1'b0;
  logic [3:0] link_flt = 4'h0;
  logic scan = 1'b0;
  wire [3:0] ready;
  wire rd;
  wire [2:0] addr;
  wire [15:0] rdata;
  wire ack;
  wire [3:0] summary;
  wire led;
  wire busy;
  wire [3:0] doubt;
  wire [127:0] w;
  int miscompares = 0;
  int tests_run = 0;
  always #20 clk_i = ~clk_i;
  aisf_top #(.FP_CONFIRM_CYC(8), .LED_HALF_CYC(4)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .sample_i(sample_i), .sample_valid_i(sample_valid_i), .sample_ready_o(ready),
    .cfg_defaults_i(cfg_defaults_i), .cfg_wr_i(cfg_wr_i), .cfg_chan_i(cfg_chan_i),
    .cfg_sel_i(cfg_sel_i), .cfg_data_i(cfg_data_i), .field_power_dist_fault_i(fp_dist),
    .field_power_local_fault_i(fp_local), .internal_link_fault_i(link_flt),
    .image_rd_i(rd), .image_addr_i(addr), .image_data_o(rdata), .image_ack_o(ack),
    .chan_summary_o(summary), .fault_led_o(led));
  aisf_nia_model u_nia (.clk_i(clk_i), .rst_i(rst_i), .scan_i(scan), .image_data_i(rdata),
    .image_ack_i(ack), .image_rd_o(rd), .image_addr_o(addr), .words_o(w), .doubt_o(doubt),
    .busy_o(busy));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value at %0t ns: %s got %h want %h", $time, msg, got, exp);
      miscompares++;
    end
  endtask
  task automatic cfg(input logic [1:0] ch, input logic [2:0] sel, input logic [15:0] d);
    cfg_chan_i = ch;
    cfg_sel_i = sel;
    cfg_data_i = d;
    cfg_wr_i = 1'b1;
    tick(1);
    cfg_wr_i = 1'b0;
    tick(1);
  endtask
  // result lands 45 edges after the taken sample
  task automatic samp(input int ch, input logic [15:0] v);
    int k;
    k = 0;
    sample_i[16*ch +: 16] = v;
    sample_valid_i[ch] = 1'b1;
    while (ready[ch] !== 1'b1 && k < 100) begin
      tick(1);
      k++;
    end
    // a channel that never takes a sample is a hang, not a pass
    if (k >= 100) miscompares++;
    tick(1);
    sample_valid_i[ch] = 1'b0;
    tick(47);
  endtask
  task automatic scan_img;
    int k;
    k = 0;
    scan = 1'b1;
    tick(1);
    scan = 1'b0;
    while (busy === 1'b1 && k < 100) begin
      tick(1);
      k++;
    end
    if (k >= 100) miscompares++;
  endtask
  task automatic t_lim(input logic [2:0] r, input logic [15:0] v, input logic [15:0] ed,
                       input logic [7:0] es);
    cfg(2'h0, `AISF_CFG_RANGE, {13'h0, r});
    samp(0, v);
    scan_img;
    chk(w[15:0], ed, "data");
    chk(w[31:16], {8'h00, es}, "status");
  endtask
  task automatic t_defaults;
    for (int c = 0; c < 4; c++) samp(c, 16'h9c40 + c[15:0]);
    scan_img;
    for (int c = 0; c < 4; c++) begin
      chk(w[32*c +: 16], 16'h9c40 + c[15:0], "default data");
      chk(w[32*c+16 +: 16], 16'h0000, "default status");
    end
  endtask
  task automatic t_limits;
    t_lim(`AISF_RNG_U1_5, 16'hffff, 16'h0000, 8'h10);
    t_lim(`AISF_RNG_U1_5, 16'hfd01, 16'h0000, 8'h30);
    t_lim(`AISF_RNG_U0_5, 16'h02ff, 16'h02ff, 8'h10);
    t_lim(`AISF_RNG_U0_5, 16'h0000, 16'h0000, 8'h30);
    t_lim(`AISF_RNG_U0_5, 16'h7fff, 16'h7fff, 8'h0d);
    t_lim(`AISF_RNG_U0_10, 16'h0300, 16'h0300, 8'h00);
    t_lim(`AISF_RNG_U0_10, 16'hfffb, 16'h0000, 8'h30);
    t_lim(`AISF_RNG_BI5, 16'h8000, 16'h8000, 8'h31);
    t_lim(`AISF_RNG_BI10, 16'h7d00, 16'h7d00, 8'h00);
    t_lim(`AISF_RNG_BI10, 16'h7d01, 16'h7d01, 8'h04);
    t_lim(`AISF_RNG_BI10, 16'h7fff, 16'h7fff, 8'h0d);
    t_lim(`AISF_RNG_BI10, 16'h82ff, 16'h82ff, 8'h10);
    t_lim(`AISF_RNG_BI10, 16'h8002, 16'h8002, 8'h10);
    t_lim(`AISF_RNG_BI10, 16'h8001, 16'h8001, 8'h31);
  endtask
  task automatic t_offset;
    cfg(2'h0, `AISF_CFG_OFFSET, 16'h03e8);
    cfg(2'h0, `AISF_CFG_MAXCNT, 16'h4268);
    t_lim(`AISF_RNG_BI10, 16'h4269, 16'h7d02, 8'h04);
    cfg(2'h0, `AISF_CFG_OFFSET, 16'h0000);
    cfg(2'h0, `AISF_CFG_MAXCNT, 16'h7d00);
  endtask
  task automatic t_avg;
    cfg(2'h0, `AISF_CFG_AVG, 16'h0002);
    cfg(2'h0, `AISF_CFG_AVG, 16'h0051);
    samp(0, 16'h03e8);
    samp(0, 16'h0bb8);
    scan_img;
    chk(w[15:0], 16'h07d0, "average of two");
    cfg(2'h0, `AISF_CFG_AVG, 16'h0001);
  endtask
  task automatic t_faults;
    fp_local = 1'b1;
    tick(3);
    chk({12'h0, summary}, 16'h000f, "local fault late");
    fp_local = 1'b0;
    fp_dist = 1'b1;
    tick(3);
    chk({12'h0, summary}, 16'h0000, "dist fault early");
    tick(10);
    scan_img;
    chk(w[127:112], 16'h0003, "power status");
    fp_dist = 1'b0;
    link_flt = 4'h2;
    tick(14);
    scan_img;
    chk(w[63:48], 16'h0081, "link status");
    chk({12'h0, doubt}, 16'h0002, "doubt flags");
  endtask
  task automatic t_disable;
    logic seen;
    seen = 1'b0;
    cfg(2'h1, `AISF_CFG_ENABLE, 16'h0000);
    tick(2);
    repeat (20) begin
      tick(1);
      seen = seen | led;
    end
    chk({15'h0, seen}, 16'h0000, "led from off channel");
    scan_img;
    chk(w[47:32], 16'h0000, "off data");
    chk(w[63:48], 16'h0000, "off status");
    for (int c = 0; c < 4; c++) cfg(c[1:0], `AISF_CFG_ENABLE, 16'h0000);
    link_flt = 4'h0;
    fp_dist = 1'b1;
    repeat (30) begin
      tick(1);
      seen = seen | led;
    end
    chk({15'h0, seen}, 16'h0001, "led with all off");
    fp_dist = 1'b0;
    cfg_defaults_i = 1'b1;
    tick(1);
    cfg_defaults_i = 1'b0;
    tick(12);
    samp(2, 16'h1234);
    scan_img;
    chk(w[79:64], 16'h1234, "enabled again");
  endtask
  task finish_test;
    if (miscompares == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    tick(12);
    rst_i = 1'b0;
    tick(1);
    t_defaults;
    t_limits;
    t_offset;
    t_avg;
    t_faults;
    t_disable;
    finish_test;
  end
  initial begin
    #400000;
    miscompares++;
    finish_test;
  end
endmodule // aisf_top_bench
`default_nettype wire
